// *** src/soc_regs.sv ***
// Notes on behaviour
// - Loop lock status byte is read only, resets to 04, writes ignored.
// - Synthesizer output enable byte, read/write, resets to 8F.
// - Synthesizer run byte, separate from enable, resets to 0F.
// - Synthesizer multiplier N of 14 bits over two bytes, resets 00 and 01.
// - Synthesizer coarse phase byte, read/write, resets to 00.
// - Synthesizer fine phase alignment byte, read/write, resets to 00.
// - Synthesizer frame pulse rate byte resets 05, style byte resets 83.
// - Synthesizer pulse shift low sixteen bits in two bytes, reset zero.
// - Pulse shift bits 21 to 16 in a third byte, reset zero.
// - High rate path enable byte resets 8F, run byte resets 0F.
// - High rate clock select byte, read/write, resets to 42.
// - High rate coarse and fine phase bytes, read/write, reset 00.
// - High rate pulse rate byte resets 05, style byte resets 23.
// - High rate pulse shift low sixteen bits in two bytes, reset zero.
// - Pair output control byte resets A3, rate byte resets 53.
// - Feedback fine phase alignment byte, read/write, resets to F5.
// - Input monitor profile select byte, read/write, resets to 00.
// - Profile A multiplier N of 14 bits over two bytes, reset zero.
// - Profile A edge low and high limit bytes, reset zero.
// - Profile A period low limit, lowest byte read/write, reset zero.
// - Each profile holds monitoring cycle count stored minus one.
// - Each profile holds quarter rate reference select control.
module soc_regs
  import soc_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Lock state from loop logic, same clock
  input  wire logic [7:0]                  lock_state_in,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output      logic                        s_axi_awready,
  input  wire logic [soc_pkg::SOC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output      logic                        s_axi_wready,
  input  wire logic [soc_pkg::SOC_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output      logic [1:0]                  s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output      logic                        s_axi_arready,
  input  wire logic [soc_pkg::SOC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  // AXI4-Lite read data
  output      logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output      logic [soc_pkg::SOC_DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]                  s_axi_rresp,
  // Configuration to the output and monitor logic
  output      soc_pkg::soc_cfg_t           cfg
);

  import soc_pkg::*;

  logic [7:0]              reg_ff [SOC_NREG];
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [SOC_DATA_W-1:0]   rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    aw_held_ff;
  logic                    w_held_ff;
  logic [SOC_ADDR_W-1:0]   awaddr_ff;
  logic [7:0]              wbyte_ff;
  logic                    wlane_ff;
  logic [SOC_NREG-1:0]     wr_hit;
  logic [SOC_NREG-1:0]     rd_hit;
  logic                    aw_take;
  logic                    w_take;
  logic                    do_write;
  logic                    ar_take;
  logic [7:0]              nxt_rbyte;

  assign aw_take  = s_axi_awvalid & awready_ff;
  assign w_take   = s_axi_wvalid & wready_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign ar_take  = s_axi_arvalid & arready_ff;

  // Word decode; bits above the index must be zero
  genvar gi;
  generate
    for (gi = 0; gi < SOC_NREG; gi++) begin : g_dec
      assign wr_hit[gi] =
        (awaddr_ff[SOC_IDX_MSB:SOC_IDX_LSB] == SOC_IDX[gi]) &&
        (awaddr_ff[SOC_ADDR_W-1:SOC_IDX_MSB+1] == '0);
      assign rd_hit[gi] =
        (s_axi_araddr[SOC_IDX_MSB:SOC_IDX_LSB] == SOC_IDX[gi]) &&
        (s_axi_araddr[SOC_ADDR_W-1:SOC_IDX_MSB+1] == '0);
    end
  endgenerate

  // Write address and data taken in either order
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (aw_take) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else if (!aw_held_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wbyte_ff  <= 8'h00;
      wlane_ff  <= 1'b0;
    end else if (w_take) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b1;
      wbyte_ff  <= s_axi_wdata[7:0];
      wlane_ff  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else if (!w_held_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  // Response only after both halves; unmapped words answer SLVERR
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= SOC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (|wr_hit) ? SOC_RESP_OKAY : SOC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Register storage, one byte per word
  generate
    for (gi = 0; gi < SOC_NREG; gi++) begin : g_reg
      if (gi == SOC_E_LOCK) begin : g_ro
        always_ff @(posedge ref_clk) begin
          if (sys_rst) begin
            reg_ff[gi] <= SOC_RST[gi];
          end else begin
            reg_ff[gi] <= lock_state_in;
          end
        end
      end else begin : g_rw
        always_ff @(posedge ref_clk) begin
          if (sys_rst) begin
            reg_ff[gi] <= SOC_RST[gi] & SOC_WMASK[gi];
          end else if (do_write && wr_hit[gi] && wlane_ff) begin
            reg_ff[gi] <= wbyte_ff & SOC_WMASK[gi];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rbyte = 8'h00;
    for (int i = 0; i < SOC_NREG; i++) begin
      if (rd_hit[i]) begin
        nxt_rbyte = nxt_rbyte | reg_ff[i];
      end
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= SOC_RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {24'h000000, nxt_rbyte};
      rresp_ff   <= (|rd_hit) ? SOC_RESP_OKAY : SOC_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Field view of the stored bytes; wiring only, no logic
  // Synthesizer path: enables, multiplier, phases and pulse fields
  assign cfg.prog.output_enable = reg_ff[SOC_E_P_EN];
  assign cfg.prog.output_run    = reg_ff[SOC_E_P_RUN];
  assign cfg.prog.mult          = {reg_ff[SOC_E_P_MULT_HI][5:0],
                                   reg_ff[SOC_E_P_MULT_LO]};
  assign cfg.prog.coarse_phase  = reg_ff[SOC_E_P_COARSE];
  assign cfg.prog.fine_phase    = reg_ff[SOC_E_P_FINE];
  assign cfg.prog.pulse_rate    = reg_ff[SOC_E_P_RATE];
  assign cfg.prog.pulse_style   = reg_ff[SOC_E_P_STYLE];
  assign cfg.prog.pulse_shift   = {reg_ff[SOC_E_P_SHIFT2][5:0],
                                   reg_ff[SOC_E_P_SHIFT1],
                                   reg_ff[SOC_E_P_SHIFT0]};

  assign cfg.hirate.output_enable = reg_ff[SOC_E_H_EN];
  assign cfg.hirate.output_run    = reg_ff[SOC_E_H_RUN];
  assign cfg.hirate.mult          = {6'h00, reg_ff[SOC_E_H_CLKSEL]};
  assign cfg.hirate.coarse_phase  = reg_ff[SOC_E_H_COARSE];
  assign cfg.hirate.fine_phase    = reg_ff[SOC_E_H_FINE];
  assign cfg.hirate.pulse_rate    = reg_ff[SOC_E_H_RATE];
  assign cfg.hirate.pulse_style   = reg_ff[SOC_E_H_STYLE];
  assign cfg.hirate.pulse_shift   = {reg_ff[SOC_E_H_SHIFT2][5:0],
                                     reg_ff[SOC_E_H_SHIFT1],
                                     reg_ff[SOC_E_H_SHIFT0]};

  assign cfg.pair_output_control = reg_ff[SOC_E_PAIR_CTRL];
  assign cfg.pair_output_rate    = reg_ff[SOC_E_PAIR_RATE];
  assign cfg.feedback_fine_phase = reg_ff[SOC_E_FB_FINE];
  assign cfg.input_monitor_profile = reg_ff[SOC_E_MON_PROF];

  assign cfg.profile_a.mult = {reg_ff[SOC_E_A_MULT_HI][5:0],
                               reg_ff[SOC_E_A_MULT_LO]};
  assign cfg.profile_a.edge_low_limit  = reg_ff[SOC_E_A_EDGE_LO];
  assign cfg.profile_a.edge_high_limit = reg_ff[SOC_E_A_EDGE_HI];
  assign cfg.profile_a.period_low_limit  = {reg_ff[SOC_E_A_PLO1],
                                            reg_ff[SOC_E_A_PLO0]};
  assign cfg.profile_a.period_high_limit = {reg_ff[SOC_E_A_PHI1],
                                            reg_ff[SOC_E_A_PHI0]};
  assign cfg.profile_a.cycles_minus_one  = reg_ff[SOC_E_A_CYC];
  assign cfg.profile_b_cycles_minus_one  = reg_ff[SOC_E_B_CYC];
  assign cfg.profile_a.quarter_rate_reference = reg_ff[SOC_E_A_QUARTER];
  assign cfg.profile_b_quarter_rate_reference = reg_ff[SOC_E_B_QUARTER];

endmodule : soc_regs

// *** include/soc_pkg.sv ***
package soc_pkg;

  localparam int SOC_NREG      = 38;
  localparam int SOC_ADDR_W    = 12;
  localparam int SOC_DATA_W    = 32;
  localparam int SOC_IDX_LSB   = 2;
  localparam int SOC_IDX_MSB   = 9;
  localparam logic [1:0] SOC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SOC_RESP_SLVERR = 2'h2;

  // Entry numbers within the register array
  localparam int SOC_E_LOCK       = 0;
  localparam int SOC_E_P_EN       = 1;
  localparam int SOC_E_P_RUN      = 2;
  localparam int SOC_E_P_MULT_LO  = 3;
  localparam int SOC_E_P_MULT_HI  = 4;
  localparam int SOC_E_P_COARSE   = 5;
  localparam int SOC_E_P_FINE     = 6;
  localparam int SOC_E_P_RATE     = 7;
  localparam int SOC_E_P_STYLE    = 8;
  localparam int SOC_E_P_SHIFT0   = 9;
  localparam int SOC_E_P_SHIFT1   = 10;
  localparam int SOC_E_P_SHIFT2   = 11;
  localparam int SOC_E_H_EN       = 12;
  localparam int SOC_E_H_RUN      = 13;
  localparam int SOC_E_H_CLKSEL   = 14;
  localparam int SOC_E_H_COARSE   = 15;
  localparam int SOC_E_H_FINE     = 16;
  localparam int SOC_E_H_RATE     = 17;
  localparam int SOC_E_H_STYLE    = 18;
  localparam int SOC_E_H_SHIFT0   = 19;
  localparam int SOC_E_H_SHIFT1   = 20;
  localparam int SOC_E_H_SHIFT2   = 21;
  localparam int SOC_E_PAIR_CTRL  = 22;
  localparam int SOC_E_PAIR_RATE  = 23;
  localparam int SOC_E_FB_FINE    = 24;
  localparam int SOC_E_MON_PROF   = 25;
  localparam int SOC_E_A_MULT_LO  = 26;
  localparam int SOC_E_A_MULT_HI  = 27;
  localparam int SOC_E_A_EDGE_LO  = 28;
  localparam int SOC_E_A_EDGE_HI  = 29;
  localparam int SOC_E_A_PLO0     = 30;
  localparam int SOC_E_A_PLO1     = 31;
  localparam int SOC_E_A_PHI0     = 32;
  localparam int SOC_E_A_PHI1     = 33;
  localparam int SOC_E_A_CYC      = 34;
  localparam int SOC_E_A_QUARTER  = 35;
  localparam int SOC_E_B_CYC      = 36;
  localparam int SOC_E_B_QUARTER  = 37;

  // Register index; byte address is four times this
  localparam logic [7:0] SOC_IDX [SOC_NREG] = '{
    8'h28, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3d, 8'h3e,
    8'h3f, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51, 8'h52, 8'h53,
    8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h60, 8'h61,
    8'h63, 8'h65, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c,
    8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h79, 8'h7a};

  localparam logic [7:0] SOC_RST [SOC_NREG] = '{
    8'h04, 8'h8f, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05,
    8'h83, 8'h00, 8'h00, 8'h00, 8'h8f, 8'h0f, 8'h42, 8'h00,
    8'h00, 8'h05, 8'h23, 8'h00, 8'h00, 8'h00, 8'ha3, 8'h53,
    8'hf5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Implemented bits; the upper two bits of 14 and 22 bit values read zero
  localparam logic [7:0] SOC_WMASK [SOC_NREG] = '{
    8'h00, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  typedef struct packed {
    logic [7:0]  output_enable;
    logic [7:0]  output_run;
    logic [13:0] mult;
    logic [7:0]  coarse_phase;
    logic [7:0]  fine_phase;
    logic [7:0]  pulse_rate;
    logic [7:0]  pulse_style;
    logic [21:0] pulse_shift;
  } soc_path_cfg_t;

  typedef struct packed {
    logic [13:0] mult;
    logic [7:0]  edge_low_limit;
    logic [7:0]  edge_high_limit;
    logic [15:0] period_low_limit;
    logic [15:0] period_high_limit;
    logic [7:0]  cycles_minus_one;
    logic [7:0]  quarter_rate_reference;
  } soc_profile_cfg_t;

  typedef struct packed {
    soc_path_cfg_t    prog;
    soc_path_cfg_t    hirate;
    logic [7:0]       pair_output_control;
    logic [7:0]       pair_output_rate;
    logic [7:0]       feedback_fine_phase;
    logic [7:0]       input_monitor_profile;
    soc_profile_cfg_t profile_a;
    logic [7:0]       profile_b_cycles_minus_one;
    logic [7:0]       profile_b_quarter_rate_reference;
  } soc_cfg_t;

endpackage : soc_pkg

// *** verification/soc_regs_properties.sv ***
module soc_regs_chk
  import soc_pkg::*;
(
  // Clock and reset
  input wire logic                            ref_clk,
  input wire logic                            sys_rst,
  // Write channels
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic                            s_axi_wvalid,
  input wire logic                            s_axi_wready,
  input wire logic                            s_axi_bvalid,
  input wire logic                            s_axi_bready,
  input wire logic [1:0]                      s_axi_bresp,
  // Read channels
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [soc_pkg::SOC_ADDR_W-1:0]  s_axi_araddr,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready,
  input wire logic [soc_pkg::SOC_DATA_W-1:0]  s_axi_rdata,
  input wire logic [1:0]                      s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ready_back;
    s_axi_awready && s_axi_wready && s_axi_arready;
  endsequence
  a_reset_idle: assert property ($fell(sys_rst) |->
    !s_axi_bvalid && !s_axi_rvalid ##1 s_ready_back)
    else $error("bus not idle after reset");
  a_write_answer: assert property (s_wr_take |=>
    !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_busy_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_answer: assert property (s_rd_take |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_err: assert property (s_rd_take ##0
    s_axi_araddr[11:10] != 2'h0 |=> s_axi_rresp == SOC_RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("outside read not refused");
  a_ready_return: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid ##1 s_axi_arready) else $error("arready not back");
  a_mask_bits: assert property (s_rd_take ##0
    s_axi_araddr == 12'h0e4 |=> s_axi_rdata[7:6] == 2'h0)
    else $error("multiplier high bits set");
endmodule : soc_regs_chk

bind soc_regs soc_regs_chk u_chk (.ref_clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// *** verification/synth_output_config_regs_test.sv ***
module synth_output_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import soc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  lock_state_in;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  soc_cfg_t    cfg;
  logic [7:0]  mdl [256];
  logic [7:0]  wm [256];
  logic        mp [256];
  logic [33:0] rq [$];
  logic [33:0] bq [$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 79289;
  // Gaps in the map and one word outside it
  logic [11:0] rsv [4] = '{12'h0a4, 12'h0ec, 12'h1ec, 12'h4d8};

  always #50 ref_clk = ~ref_clk;

  soc_regs DUT (.ref_clk, .sys_rst, .lock_state_in, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .cfg);

  task automatic check(input string nm, input logic [33:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Field view against the byte model
  task automatic cfg_chk;
    check("p en", 34'(cfg.prog.output_enable), 34'(mdl[8'h36]));
    check("p run", 34'(cfg.prog.output_run), 34'(mdl[8'h37]));
    check("p mult", 34'(cfg.prog.mult),
          34'({mdl[8'h39][5:0], mdl[8'h38]}));
    check("p coarse", 34'(cfg.prog.coarse_phase), 34'(mdl[8'h3a]));
    check("p fine", 34'(cfg.prog.fine_phase), 34'(mdl[8'h3d]));
    check("p rate", 34'(cfg.prog.pulse_rate), 34'(mdl[8'h3e]));
    check("p style", 34'(cfg.prog.pulse_style), 34'(mdl[8'h3f]));
    check("p shift", 34'(cfg.prog.pulse_shift),
          34'({mdl[8'h42][5:0], mdl[8'h41], mdl[8'h40]}));
    check("h en", 34'(cfg.hirate.output_enable), 34'(mdl[8'h50]));
    check("h run", 34'(cfg.hirate.output_run), 34'(mdl[8'h51]));
    check("h clock", 34'(cfg.hirate.mult), 34'(mdl[8'h52]));
    check("h coarse", 34'(cfg.hirate.coarse_phase), 34'(mdl[8'h53]));
    check("h fine", 34'(cfg.hirate.fine_phase), 34'(mdl[8'h55]));
    check("h rate", 34'(cfg.hirate.pulse_rate), 34'(mdl[8'h56]));
    check("h style", 34'(cfg.hirate.pulse_style), 34'(mdl[8'h57]));
    check("h shift", 34'(cfg.hirate.pulse_shift),
          34'({mdl[8'h5a][5:0], mdl[8'h59], mdl[8'h58]}));
    check("pair ctl", 34'(cfg.pair_output_control), 34'(mdl[8'h60]));
    check("pair rate", 34'(cfg.pair_output_rate), 34'(mdl[8'h61]));
    check("fb fine", 34'(cfg.feedback_fine_phase), 34'(mdl[8'h63]));
    check("profile", 34'(cfg.input_monitor_profile),
          34'(mdl[8'h65]));
    check("a mult", 34'(cfg.profile_a.mult),
          34'({mdl[8'h68][5:0], mdl[8'h67]}));
    check("a edge lo", 34'(cfg.profile_a.edge_low_limit),
          34'(mdl[8'h69]));
    check("a edge hi", 34'(cfg.profile_a.edge_high_limit),
          34'(mdl[8'h6a]));
    check("a per lo", 34'(cfg.profile_a.period_low_limit),
          34'({mdl[8'h6c], mdl[8'h6b]}));
    check("a per hi", 34'(cfg.profile_a.period_high_limit),
          34'({mdl[8'h6e], mdl[8'h6d]}));
    check("a cycles", 34'(cfg.profile_a.cycles_minus_one),
          34'(mdl[8'h6f]));
    check("a quarter", 34'(cfg.profile_a.quarter_rate_reference),
          34'(mdl[8'h70]));
    check("b cycles", 34'(cfg.profile_b_cycles_minus_one),
          34'(mdl[8'h79]));
    check("b quarter", 34'(cfg.profile_b_quarter_rate_reference),
          34'(mdl[8'h7a]));
  endtask : cfg_chk

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad

  // Model reloads with the device, lock byte tracks its input
  task automatic reset_all;
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int j = 0; j < 256; j++) begin
      mdl[j] = 8'h0;
      mp[j] = 1'b0;
    end
    for (int i = 0; i < SOC_NREG; i++) begin
      mdl[SOC_IDX[i]] = SOC_RST[i];
      wm[SOC_IDX[i]] = SOC_WMASK[i];
      mp[SOC_IDX[i]] = 1'b1;
    end
    mdl[8'h28] = lock_state_in;
  endtask : reset_all

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    logic ok, ta, tw;
    int n;
    ok = a[11:10] == 2'h0 && mp[a[9:2]];
    bq.push_back({ok ? SOC_RESP_OKAY : SOC_RESP_SLVERR, 32'h0});
    if (ok && s[0] && wm[a[9:2]] != 8'h0) mdl[a[9:2]] = d & wm[a[9:2]];
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($random(seed));
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'($random(seed)), d};
    s_axi_wstrb <= s;
    ta = 1'b0;
    tw = 1'b0;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    // Random stall exercises the response hold
    n = {$random(seed)} % 4;
    repeat (n) @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic ok;
    int n;
    ok = a[11:10] == 2'h0 && mp[a[9:2]];
    rq.push_back(ok ? {SOC_RESP_OKAY, 24'h0, mdl[a[9:2]]}
                    : {SOC_RESP_SLVERR, 32'h0});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($random(seed));
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    n = {$random(seed)} % 4;
    repeat (n) @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check("write resp", {s_axi_bresp, 32'h0}, bq.pop_front());
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 57'h0;
    {s_axi_wstrb, s_axi_awprot, s_axi_arprot} = 10'h0;
    lock_state_in = 8'($random(seed));
    reset_all;
    for (int i = 0; i < SOC_NREG; i++) rd(ad(SOC_IDX[i]));
    cfg_chk;
    for (int i = 0; i < SOC_NREG; i++)
      wr(ad(SOC_IDX[i]), 8'($random(seed)), 4'h1);
    for (int i = 0; i < SOC_NREG; i++) rd(ad(SOC_IDX[i]));
    cfg_chk;
    wr(ad(8'h36), 8'h11, 4'h0);
    rd(ad(8'h36));
    foreach (rsv[k]) begin
      wr(rsv[k], 8'hff, 4'h1);
      rd(rsv[k]);
    end
    rd(ad(8'h36));
    cfg_chk;
    lock_state_in <= ~lock_state_in;
    mdl[8'h28] = ~lock_state_in;
    @(posedge ref_clk);
    rd(ad(8'h28));
    reset_all;
    for (int i = 0; i < SOC_NREG; i++) rd(ad(SOC_IDX[i]));
    cfg_chk;
    results;
  end
endmodule : synth_output_config_regs_test
